// file: hw/pde_pkg.sv
// constants shared by the port d/e pin override block
package pde_pkg;
  // register byte addresses (avalon word aligned)
  localparam logic [3:0] ADDR_CFG     = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_PIN     = 4'h8;
  localparam logic [3:0] ADDR_PE_VIEW = 4'hc;
  // configuration register fields
  localparam int         CFG_W        = 7;
  localparam int         CFG_PULLUP_DISABLE = 0;
  localparam int         CFG_ACMP0D   = 1;
  localparam int         CFG_ADC3D    = 2;
  localparam int         CFG_ADC2D    = 3;
  localparam int         CFG_ADC1D    = 4;
  localparam int         CFG_ADC0D    = 5;
  localparam int         CFG_INT0EN   = 6;
  localparam logic [6:0] CFG_RESET    = 7'h00;
  // status and view field positions
  localparam int         ST_PE_LSB    = 5;
  localparam int         ST_RST_MODE  = 8;
  localparam int         ST_OSC_IN    = 9;
  localparam int         ST_OSC_OUT   = 10;
  localparam int         VIEW_OUT_LSB = 4;
endpackage

// file: hw/pde_pin_override.sv
// pin override logic for port d bits 7..3 and port e bits 2..0
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.

// Operation
// (RULE1) pd3 direction override value equals the serial transmitter enable.
// (RULE2) pe2 used as oscillator output is never a general-purpose pin.
// (RULE3) pe1 is oscillator input unless internal rc clock; then no general i/o.
// (RULE4) timer0 compare-b reaches pe1 only while its direction bit is one.
// (RULE5) reset-disable fuse programmed: pe0 is ordinary i/o, no pin reset.
// (RULE6) reset-disable fuse unprogrammed: pe0 feeds reset circuitry, no i/o.
// (RULE7) while pe0 is reset input its direction, output, input read zero.
// (RULE8) receiver enabled forces pd4 input; output data bit then enables pull-up.
// (RULE9) transmitter enabled forces pd3 to output regardless of direction bit.
// (RULE10) spi slave forces pd4 input; spi master leaves direction to port bit.
// (RULE11) an asserted override enable replaces the port register value per attribute.
module pde_pin_override (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [7:3]  i_portd_output,
  input  wire logic [7:3]  i_portd_direction,
  input  wire logic [2:0]  i_porte_output,
  input  wire logic [2:0]  i_porte_direction,
  input  wire logic        i_serial_tx_enable,
  input  wire logic        i_serial_tx_data,
  input  wire logic        i_serial_rx_enable,
  input  wire logic        i_spi_enable_bit,
  input  wire logic        i_spi_master_select,
  input  wire logic        i_spi_pin_set_select,
  input  wire logic        i_spi_sck_out,
  input  wire logic        i_spi_mosi_out,
  input  wire logic        i_timer0_compare_a_en,
  input  wire logic        i_timer0_compare_a_out,
  input  wire logic        i_timer0_compare_b_en,
  input  wire logic        i_timer0_compare_b_out,
  input  wire logic        i_clk_src_internal_rc,
  input  wire logic        i_xtal_output_used,
  input  wire logic        i_reset_pin_disable_fuse,
  input  wire logic [7:3]  i_pd_pin,
  input  wire logic [2:0]  i_pe_pin,
  output logic      [7:3]  o_pd_out,
  output logic      [7:3]  o_pd_oe,
  output logic      [7:3]  o_pd_pullup,
  output logic      [7:3]  o_pd_din,
  output logic      [2:0]  o_pe_out,
  output logic      [2:0]  o_pe_oe,
  output logic      [2:0]  o_pe_pullup,
  output logic      [2:0]  o_pe_din,
  output logic      [2:0]  o_porte_read_direction,
  output logic      [2:0]  o_porte_read_output,
  output logic      [2:0]  o_porte_read_input,
  output logic             o_ext_reset_req
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // override enable selects the override value, else the port value
  function automatic logic pde_ovr(input logic en, input logic val, input logic base);
    pde_ovr = en ? val : base;
  endfunction

  logic [pde_pkg::CFG_W-1:0] cfg;
  logic [7:3] pd_meta;
  logic [7:3] pd_sync;
  logic [2:0] pe_meta;
  logic [2:0] pe_sync;
  logic       fuse_q;
  logic       fuse_done;
  logic       avs_ack;
  logic       global_pullup_disable;
  logic       spi_slave;
  logic       spi_master;
  logic       osc_in_mode;
  logic       rst_mode;
  logic [7:3] pd_base_pu;
  logic [2:0] pe_base_pu;
  logic [7:3] pd_die;
  logic [2:0] pe_die;
  logic [7:3] next_pd_out;
  logic [7:3] next_pd_oe;
  logic [7:3] next_pd_pu;
  logic [2:0] next_pe_out;
  logic [2:0] next_pe_oe;
  logic [2:0] next_pe_pu;
  logic [2:0] next_pe_din;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // pin synchronisers and fuse capture
  // ----------------------------------------------------------------
  // pads are asynchronous, two flops before any logic looks at them
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pd_meta <= '0;
      pd_sync <= '0;
      // pe0 idles high under its pull-up; a zero here would fake a reset request
      pe_meta <= 3'h1;
      pe_sync <= 3'h1;
    end else begin
      pd_meta <= i_pd_pin;
      pd_sync <= pd_meta;
      pe_meta <= i_pe_pin;
      pe_sync <= pe_meta;
    end
  end

  // fuse taken once after release; until then pe0 stays a reset pin
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fuse_q    <= 1'b0;
      fuse_done <= 1'b0;
    end else if (!fuse_done) begin
      fuse_q    <= i_reset_pin_disable_fuse;
      fuse_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // override decode
  // ----------------------------------------------------------------
  always_comb begin
    global_pullup_disable = cfg[pde_pkg::CFG_PULLUP_DISABLE];
    spi_slave  = i_spi_enable_bit & ~i_spi_master_select & i_spi_pin_set_select;
    spi_master = i_spi_enable_bit & i_spi_master_select & i_spi_pin_set_select;
    osc_in_mode = ~i_clk_src_internal_rc;
    rst_mode   = ~fuse_q;
    pd_base_pu = i_portd_output & ~i_portd_direction & {5{~global_pullup_disable}};
    pe_base_pu = i_porte_output & ~i_porte_direction & {3{~global_pullup_disable}};
    // pd7..pd5 have only input-disable overrides
    next_pd_oe[7:5]  = i_portd_direction[7:5];
    next_pd_out[7:5] = i_portd_output[7:5];
    next_pd_pu[7:5]  = pd_base_pu[7:5];
    // pd4: receiver or spi slave makes it an input, pull-up from data bit
    next_pd_oe[4]  = pde_ovr(i_serial_rx_enable | spi_slave, 1'b0,
                             i_portd_direction[4]);                      // RULE8 RULE10
    next_pd_pu[4]  = pde_ovr(i_serial_rx_enable | spi_slave,
                             i_portd_output[4] & ~global_pullup_disable,
                             pd_base_pu[4]);                             // RULE8
    next_pd_out[4] = pde_ovr(spi_master, i_spi_sck_out, i_portd_output[4]); // RULE11
    // pd3: transmitter owns direction, spi slave forces input
    next_pd_oe[3]  = pde_ovr(i_serial_tx_enable | spi_slave, i_serial_tx_enable,
                             i_portd_direction[3]);                      // RULE1 RULE9
    next_pd_pu[3]  = pde_ovr(i_serial_tx_enable | spi_slave,
                             ~i_serial_tx_enable & i_portd_output[3] & ~global_pullup_disable,
                             pd_base_pu[3]);
    next_pd_out[3] = pde_ovr(i_serial_tx_enable | i_timer0_compare_a_en | spi_master,
                             i_serial_tx_enable ? i_serial_tx_data :
                             (i_timer0_compare_a_en ? i_timer0_compare_a_out :
                              i_spi_mosi_out), i_portd_output[3]);
    // digital input disables; int0 keeps pd6 readable
    pd_die[7] = pde_ovr(cfg[pde_pkg::CFG_ACMP0D], 1'b0, 1'b1);
    pd_die[6] = pde_ovr(cfg[pde_pkg::CFG_ADC3D] | cfg[pde_pkg::CFG_INT0EN],
                        cfg[pde_pkg::CFG_INT0EN], 1'b1);
    pd_die[5] = pde_ovr(cfg[pde_pkg::CFG_ADC2D], 1'b0, 1'b1);
    pd_die[4] = pde_ovr(cfg[pde_pkg::CFG_ADC1D], 1'b0, 1'b1);
    pd_die[3] = 1'b1;
    // pe2: crystal output takes the whole pin
    next_pe_oe[2]  = pde_ovr(i_xtal_output_used, 1'b0, i_porte_direction[2]); // RULE2
    next_pe_pu[2]  = pde_ovr(i_xtal_output_used, 1'b0, pe_base_pu[2]);        // RULE2
    next_pe_out[2] = i_porte_output[2];
    pe_die[2]      = pde_ovr(i_xtal_output_used | cfg[pde_pkg::CFG_ADC0D], 1'b0, 1'b1);
    // pe1: oscillator input unless internal rc; compare-b needs direction one
    next_pe_oe[1]  = pde_ovr(osc_in_mode, 1'b0, i_porte_direction[1]);      // RULE3 RULE4
    next_pe_pu[1]  = pde_ovr(osc_in_mode, 1'b0, pe_base_pu[1]);             // RULE3
    next_pe_out[1] = pde_ovr(i_timer0_compare_b_en, i_timer0_compare_b_out,
                             i_porte_output[1]);                           // RULE4
    pe_die[1]      = pde_ovr(osc_in_mode, 1'b0, 1'b1);                      // RULE3
    // pe0: reset pin keeps its pull-up so a floating pad does not reset
    next_pe_oe[0]  = pde_ovr(rst_mode, 1'b0, i_porte_direction[0]);         // RULE5 RULE6
    next_pe_pu[0]  = pde_ovr(rst_mode, 1'b1, pe_base_pu[0]);                // RULE6
    next_pe_out[0] = i_porte_output[0];
    pe_die[0]      = pde_ovr(rst_mode, 1'b0, 1'b1);                         // RULE6
    next_pe_din    = pe_sync & pe_die;
  end

  // ----------------------------------------------------------------
  // registered pin drive
  // ----------------------------------------------------------------
  // outputs come from flops, so every override acts one cycle later
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pd_out    <= '0;
      o_pd_oe     <= '0;
      o_pd_pullup <= '0;
      o_pd_din    <= '0;
      o_pe_out    <= '0;
      o_pe_oe     <= '0;
      o_pe_pullup <= 3'h1;   // pe0 starts as reset pin, so its pull-up is on
      o_pe_din    <= '0;
    end else begin
      o_pd_out    <= next_pd_out;                                           // RULE11
      o_pd_oe     <= next_pd_oe;
      o_pd_pullup <= next_pd_pu;
      o_pd_din    <= pd_sync & pd_die;
      o_pe_out    <= next_pe_out;
      o_pe_oe     <= next_pe_oe;
      o_pe_pullup <= next_pe_pu;
      o_pe_din    <= next_pe_din;
    end
  end

  // reset request and software view of port e
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ext_reset_req        <= 1'b0;
      o_porte_read_direction <= '0;
      o_porte_read_output    <= '0;
      o_porte_read_input     <= '0;
    end else begin
      o_ext_reset_req        <= rst_mode & ~pe_sync[0];                     // RULE5 RULE6
      o_porte_read_direction <= {i_porte_direction[2:1],
                                 i_porte_direction[0] & ~rst_mode};          // RULE7
      o_porte_read_output    <= {i_porte_output[2:1], i_porte_output[0] & ~rst_mode};
      o_porte_read_input     <= {next_pe_din[2:1], 1'b0 & rst_mode} |
                                {2'b00, next_pe_din[0] & ~rst_mode};         // RULE7
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_avs_address)
      pde_pkg::ADDR_CFG:     next_rdata[pde_pkg::CFG_W-1:0] = cfg;
      pde_pkg::ADDR_STATUS: begin
        next_rdata[4:0]                             = o_pd_oe;
        next_rdata[pde_pkg::ST_PE_LSB+2:pde_pkg::ST_PE_LSB] = o_pe_oe;
        next_rdata[pde_pkg::ST_RST_MODE]            = rst_mode;
        next_rdata[pde_pkg::ST_OSC_IN]              = osc_in_mode;
        next_rdata[pde_pkg::ST_OSC_OUT]             = i_xtal_output_used;
      end
      pde_pkg::ADDR_PIN: begin
        next_rdata[4:0]                             = o_pd_din;
        next_rdata[pde_pkg::ST_PE_LSB+2:pde_pkg::ST_PE_LSB] = o_porte_read_input;
      end
      pde_pkg::ADDR_PE_VIEW: begin
        next_rdata[2:0]                             = o_porte_read_direction;
        next_rdata[pde_pkg::VIEW_OUT_LSB+2:pde_pkg::VIEW_OUT_LSB] = o_porte_read_output;
      end
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  // waitrequest is its own flop holding the inverse of ack, so the request is held one cycle
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      avs_ack           <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_ack           <= (i_avs_read | i_avs_write) & ~avs_ack;
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~avs_ack);
      if (i_avs_read & ~avs_ack) begin
        o_avs_readdata <= next_rdata;
      end
    end
  end

  // configuration written in the accepting cycle only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= pde_pkg::CFG_RESET;
    end else if (i_avs_write & avs_ack & i_avs_byteenable[0] &
                 (i_avs_address == pde_pkg::ADDR_CFG)) begin
      cfg <= i_avs_writedata[pde_pkg::CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_tx_dir_value: assert property (i_serial_tx_enable |=> o_pd_oe[3] &&   // RULE1
      o_pd_out[3] == $past(i_serial_tx_data)) else $error("pd3 not tx output");
  a_tx_forces_out: assert property ((i_serial_tx_enable && !i_portd_direction[3])  // RULE9
      |=> o_pd_oe[3]) else $error("tx did not force pd3 output");
  a_osc_out_no_io: assert property (i_xtal_output_used |=>               // RULE2
      !o_pe_oe[2] && !o_pe_pullup[2] && !o_pe_din[2]) else $error("pe2 used as io");
  a_osc_in_no_io: assert property (!i_clk_src_internal_rc |=>           // RULE3
      !o_pe_oe[1] && !o_pe_din[1]) else $error("pe1 used as io");
  a_cmpb_on_pin: assert property ((i_clk_src_internal_rc && i_timer0_compare_b_en) |=> // RULE4
      o_pe_oe[1] == $past(i_porte_direction[1]) &&
      o_pe_out[1] == $past(i_timer0_compare_b_out)) else $error("compare b not on pe1");
  a_pe0_io_mode: assert property ((fuse_done && fuse_q) |=>              // RULE5
      !o_ext_reset_req && o_pe_oe[0] == $past(i_porte_direction[0]))
      else $error("pe0 not plain io");
  a_pe0_reset_mode: assert property ((fuse_done && !fuse_q && !pe_sync[0]) |=> // RULE6
      o_ext_reset_req && !o_pe_oe[0]) else $error("pe0 not reset pin");
  a_pe0_reads_zero: assert property ((fuse_done && !fuse_q) |=>          // RULE7
      !o_porte_read_direction[0] && !o_porte_read_output[0] && !o_porte_read_input[0])
      else $error("pe0 view not zero");
  a_rx_forces_in: assert property (i_serial_rx_enable |=> !o_pd_oe[4] && // RULE8
      o_pd_pullup[4] == ($past(i_portd_output[4]) && !$past(global_pullup_disable)))
      else $error("rx did not force pd4 input");
  a_spi_slave_in: assert property (spi_slave |=> !o_pd_oe[4])            // RULE10
      else $error("spi slave pd4 not input");
  a_spi_master_dir: assert property ((spi_master && !i_serial_rx_enable) |=> // RULE10
      o_pd_oe[4] == $past(i_portd_direction[4])) else $error("spi master pd4 dir");
  a_no_override: assert property (!cfg[pde_pkg::CFG_ACMP0D] |=>          // RULE11
      o_pd_oe[7] == $past(i_portd_direction[7]) && o_pd_din[7] == $past(pd_sync[7]))
      else $error("pd7 not from port");

  c_tx_active: cover property (i_serial_tx_enable ##1 o_pd_oe[3]);
  c_spi_slave: cover property (spi_slave ##1 !o_pd_oe[4]);
  c_reset_pin: cover property (o_ext_reset_req);
  c_cmpb_out: cover property (i_timer0_compare_b_en && i_porte_direction[1] &&
      i_clk_src_internal_rc ##1 o_pe_oe[1]);

endmodule

// file: verification/pde_board_model.sv
// board-side model of the port d/e pads
module pde_board_model (
  input  wire logic       i_mclk,
  input  wire logic       i_pe0_hold_low,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  output logic      [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] toggle = 8'h55;
  // ---------------------------------------------------------------
  // pad levels
  // ---------------------------------------------------------------
  // a floating pad swings every cycle so a stale level never passes for a drive
  always @(posedge i_mclk) begin
    toggle <= ~toggle;
  end
  // driven pads follow the device, pulled pads sit high, a push button can ground pe0
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin[i] = i_oe[i] ? i_out[i] : (i_pullup[i] ? 1'b1 : toggle[i]);
    end
    if (i_pe0_hold_low && !i_oe[0]) begin
      o_pin[0] = 1'b0;
    end
  end
endmodule

// file: verification/port_d_e_alt_function_override_tb.sv
// self-checking bench for the port d/e pin override block
module port_d_e_alt_function_override_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic o_avs_waitrequest, o_ext_reset_req, pe0_low = 1'b0;
  logic [7:3] i_portd_output = 5'h00, i_portd_direction = 5'h00;
  logic [2:0] i_porte_output = 3'h0, i_porte_direction = 3'h0;
  logic i_serial_tx_enable = 1'b0, i_serial_tx_data = 1'b0, i_serial_rx_enable = 1'b0;
  logic i_spi_enable_bit = 1'b0, i_spi_master_select = 1'b0, i_spi_pin_set_select = 1'b1;
  logic i_spi_sck_out = 1'b0, i_spi_mosi_out = 1'b0;
  logic i_timer0_compare_a_en = 1'b0, i_timer0_compare_a_out = 1'b0;
  logic i_timer0_compare_b_en = 1'b0, i_timer0_compare_b_out = 1'b0;
  logic i_clk_src_internal_rc = 1'b1, i_xtal_output_used = 1'b0;
  logic i_reset_pin_disable_fuse = 1'b0;
  logic [7:0] pad;
  logic [7:3] o_pd_out, o_pd_oe, o_pd_pullup, o_pd_din;
  logic [2:0] o_pe_out, o_pe_oe, o_pe_pullup, o_pe_din;
  logic [2:0] o_porte_read_direction, o_porte_read_output, o_porte_read_input;
  int errors = 0;
  int cmp_count = 0;
  // 200 MHz
  always #2.5 i_mclk = ~i_mclk;
  // ---------------------------------------------------------------
  // device and board
  // ---------------------------------------------------------------
  pde_pin_override pde_pin_override_inst (.i_mclk, .i_rst_b, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_portd_output, .i_portd_direction, .i_porte_output, .i_porte_direction,
    .i_serial_tx_enable, .i_serial_tx_data, .i_serial_rx_enable, .i_spi_enable_bit,
    .i_spi_master_select, .i_spi_pin_set_select, .i_spi_sck_out, .i_spi_mosi_out,
    .i_timer0_compare_a_en, .i_timer0_compare_a_out, .i_timer0_compare_b_en,
    .i_timer0_compare_b_out, .i_clk_src_internal_rc, .i_xtal_output_used,
    .i_reset_pin_disable_fuse, .i_pd_pin(pad[7:3]), .i_pe_pin(pad[2:0]), .o_pd_out,
    .o_pd_oe, .o_pd_pullup, .o_pd_din, .o_pe_out, .o_pe_oe, .o_pe_pullup, .o_pe_din,
    .o_porte_read_direction, .o_porte_read_output, .o_porte_read_input, .o_ext_reset_req);
  pde_board_model pde_board_model_inst (.i_mclk(i_mclk), .i_pe0_hold_low(pe0_low),
    .i_out({o_pd_out, o_pe_out}), .i_oe({o_pd_oe, o_pe_oe}),
    .i_pullup({o_pd_pullup, o_pe_pullup}), .o_pin(pad));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s is %h", $time, what, got);
    end
  endtask
  // one avalon access; the request is held until waitrequest is seen low
  task automatic bus(input logic rdn, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_read <= rdn;
    i_avs_write <= ~rdn;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    n = 0;
    // waitrequest and read data are taken at the rising edge that completes the access
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 64);
    if (o_avs_waitrequest !== 1'b0) begin
      errors++;
      results();
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(negedge i_mclk);
  endtask
  // the fuse is only captured once after a reset, so each fuse setting needs one
  task automatic do_reset(input logic fuse);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    i_reset_pin_disable_fuse <= fuse;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    results();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    bus(1'b1, pde_pkg::ADDR_CFG, 32'h0, 4'hf, rd);
    chk_word(rd, {25'h0, pde_pkg::CFG_RESET}, "cfg reset");
    bus(1'b0, pde_pkg::ADDR_CFG, 32'h1, 4'h0, rd);
    bus(1'b1, pde_pkg::ADDR_CFG, 32'h0, 4'hf, rd);
    chk_word(rd, 32'h0, "cfg masked write");
    bus(1'b1, 4'h2, 32'h0, 4'hf, rd);
    chk_word(rd, 32'h0, "unmapped read");
    // pe0 as reset pin hides its port bits and feeds the reset line
    @(posedge i_mclk);
    i_porte_direction <= 3'h5;
    i_porte_output <= 3'h5;
    settle(2);
    chk_bit(o_pe_oe[0], 1'b0, "pe0 drive");
    chk_bit(o_pe_pullup[0], 1'b1, "pe0 reset pullup");
    bus(1'b1, pde_pkg::ADDR_PE_VIEW, 32'h0, 4'hf, rd);
    chk_word(rd, 32'h0000_0044, "pe view reset mode");
    chk_bit(o_porte_read_direction[0], 1'b0, "pe0 dir read");
    chk_bit(o_porte_read_output[0], 1'b0, "pe0 out read");
    chk_bit(o_ext_reset_req, 1'b0, "reset idle");
    bus(1'b1, pde_pkg::ADDR_STATUS, 32'h0, 4'hf, rd);
    chk_bit(rd[pde_pkg::ST_RST_MODE], 1'b1, "reset mode flag");
    @(posedge i_mclk);
    pe0_low <= 1'b1;
    settle(5);
    chk_bit(o_ext_reset_req, 1'b1, "reset request");
    chk_bit(o_porte_read_input[0], 1'b0, "pe0 in read");
    @(posedge i_mclk);
    pe0_low <= 1'b0;
    // fuse programmed: pe0 is plain i/o
    do_reset(1'b1);
    settle(5);
    chk_bit(o_pe_oe[0], 1'b1, "pe0 io drive");
    chk_bit(o_pe_out[0], 1'b1, "pe0 io value");
    chk_bit(o_porte_read_input[0], 1'b1, "pe0 io input");
    chk_bit(o_ext_reset_req, 1'b0, "no pin reset");
    bus(1'b1, pde_pkg::ADDR_PE_VIEW, 32'h0, 4'hf, rd);
    chk_word(rd, 32'h0000_0055, "pe view io mode");
    // transmitter takes pd3 whatever its direction bit says
    @(posedge i_mclk);
    i_serial_tx_enable <= 1'b1;
    i_serial_tx_data <= 1'b1;
    i_portd_direction <= 5'h12;
    i_portd_output <= 5'h12;
    settle(2);
    chk_bit(o_pd_oe[3], 1'b1, "pd3 tx drive");
    chk_bit(o_pd_out[3], 1'b1, "pd3 tx data");
    chk_bit(o_pd_oe[7], 1'b1, "pd7 port drive");
    @(posedge i_mclk);
    i_serial_tx_enable <= 1'b0;
    i_serial_rx_enable <= 1'b1;
    settle(2);
    chk_bit(o_pd_oe[3], 1'b0, "pd3 released");
    chk_bit(o_pd_oe[4], 1'b0, "pd4 rx input");
    chk_bit(o_pd_pullup[4], 1'b1, "pd4 rx pullup");
    chk_bit(o_pd_din[7], 1'b1, "pd7 input on");
    bus(1'b0, pde_pkg::ADDR_CFG, 32'h3, 4'h1, rd);
    settle(2);
    chk_bit(o_pd_pullup[4], 1'b0, "pd4 pullup disabled");
    chk_bit(o_pd_din[7], 1'b0, "pd7 input disabled");
    bus(1'b0, pde_pkg::ADDR_CFG, 32'h0, 4'h1, rd);
    // spi slave forces pd4 in; master leaves it to the port bit
    @(posedge i_mclk);
    i_serial_rx_enable <= 1'b0;
    i_spi_enable_bit <= 1'b1;
    settle(2);
    chk_bit(o_pd_oe[4], 1'b0, "pd4 slave input");
    @(posedge i_mclk);
    i_spi_master_select <= 1'b1;
    settle(2);
    chk_bit(o_pd_oe[4], 1'b1, "pd4 master drive");
    chk_bit(o_pd_out[4], 1'b0, "pd4 sck value");
    // compare b reaches pe1 only with its direction bit set and no crystal
    @(posedge i_mclk);
    i_spi_enable_bit <= 1'b0;
    i_timer0_compare_b_en <= 1'b1;
    i_timer0_compare_b_out <= 1'b1;
    settle(2);
    chk_bit(o_pe_oe[1], 1'b0, "pe1 dir zero");
    @(posedge i_mclk);
    i_porte_direction <= 3'h7;
    settle(2);
    chk_bit(o_pe_oe[1], 1'b1, "pe1 compare drive");
    chk_bit(o_pe_out[1], 1'b1, "pe1 compare value");
    chk_bit(o_pe_oe[2], 1'b1, "pe2 port drive");
    @(posedge i_mclk);
    i_clk_src_internal_rc <= 1'b0;
    i_xtal_output_used <= 1'b1;
    settle(2);
    chk_bit(o_pe_oe[1], 1'b0, "pe1 osc input");
    chk_bit(o_pe_oe[2], 1'b0, "pe2 osc output");
    chk_bit(o_pe_din[2], 1'b0, "pe2 input off");
    bus(1'b1, pde_pkg::ADDR_STATUS, 32'h0, 4'hf, rd);
    chk_bit(rd[pde_pkg::ST_OSC_IN], 1'b1, "pe1 osc flag");
    chk_bit(rd[pde_pkg::ST_OSC_OUT], 1'b1, "pe2 osc flag");
    results();
  end
endmodule
